// [design/usbt_pkg.sv]
// Package for the SOF timeout and OTG port control block
package usbt_pkg;
  // Register offsets on the plain register port
  localparam logic [15:0] ADDR_P1_FRAME = 16'hC092;
  localparam logic [15:0] ADDR_P1_COUNT = 16'hC094;
  localparam logic [15:0] ADDR_OTG_CTRL = 16'hC098;
  localparam logic [15:0] ADDR_P2_FRAME = 16'hC0B2;
  localparam logic [15:0] ADDR_P2_COUNT = 16'hC0B4;
  localparam logic [15:0] ADDR_P1_STAT = 16'hC200;
  localparam logic [15:0] ADDR_P1_IEN = 16'hC202;
  localparam logic [15:0] ADDR_P2_STAT = 16'hC204;
  localparam logic [15:0] ADDR_P2_IEN = 16'hC206;
  // Reset values
  localparam logic [13:0] COUNT_RST = 14'h2EE0;
  localparam logic [15:0] OTG_CTRL_RST = 16'h0000;
  // Frame register fields
  localparam int FRM_FLAG_BIT = 15;
  localparam int FRM_CNT_LSB = 12;
  localparam logic [2:0] TO_CNT_MAX = 3'h7;
  // Timeout flag and its enable share bit 0 of the status and enable words
  localparam int STAT_TO_BIT = 0;
  // OTG control fields
  localparam int OTG_VBUS_PU_BIT = 13;
  localparam int OTG_RX_DIS_BIT = 12;
  localparam int OTG_PUMP_BIT = 11;
  localparam int OTG_DISCH_BIT = 10;
  localparam int OTG_DP_PU_BIT = 9;
  localparam int OTG_DM_PU_BIT = 8;
  localparam int OTG_DP_PD_BIT = 7;
  localparam int OTG_DM_PD_BIT = 6;
  localparam int OTG_VBUS_LVL_BIT = 2;
  localparam int OTG_ID_BIT = 1;
  localparam int OTG_VALID_BIT = 0;
  localparam logic [15:0] OTG_WR_MASK = 16'h3FC0;
  // Time base: 12 MHz tick from 20 MHz core clock by phase accumulator
  localparam int CORE_HZ = 20000000;
  localparam int TICK_HZ = 12000000;
  localparam logic [24:0] TICK_STEP = 25'(TICK_HZ);
  localparam logic [24:0] TICK_WRAP = 25'(CORE_HZ);
  // Pin bundle for the OTG analog controls
  typedef struct packed {
    logic vbus_pu_en;
    logic rx_pwr_dn;
    logic pump_en;
    logic vbus_dis_en;
    logic dp_pu_en;
    logic dm_pu_en;
    logic dp_pd_en;
    logic dm_pd_en;
  } usbt_otg_pins_type;
  // Port-side events
  typedef struct packed {
    logic sof_seen;
    logic eop_seen;
    logic [10:0] frame_num;
    logic full_speed;
  } usbt_port_evt_type;
endpackage

// [design/usbt_sof_timer.sv]
// One port's SOF/EOP interval counter, timeout flag and frame capture
`timescale 1ns/1ps
`default_nettype none
module usbt_sof_timer
  import usbt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Time base
  input wire logic tick_en,
  // Port events (same clock domain)
  input wire usbt_port_evt_type evt,
  // Register controls
  input wire logic count_wr,
  input wire logic [13:0] count_wdata,
  input wire logic to_ien,
  input wire logic flag_clr,
  // Results
  output logic [13:0] count_ff,
  output logic [15:0] frame_reg,
  output logic to_flag_ff
);
  logic [13:0] interval_ff;
  logic [10:0] frame_ff;
  logic [2:0] to_cnt_ff;
  logic sof_or_eop;
  logic expire;

  assign sof_or_eop = evt.sof_seen | evt.eop_seen;
  // Expiry fires once as the counter reaches zero
  assign expire = tick_en && !sof_or_eop && (count_ff == 14'h0001);

  // Programmed interval, reloaded on each frame
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      interval_ff <= COUNT_RST;
    end else if (count_wr) begin
      interval_ff <= count_wdata;
    end
  end

  // Down counter; a write also restarts timing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= COUNT_RST;
    end else if (count_wr) begin
      count_ff <= count_wdata;
    end else if (sof_or_eop) begin
      count_ff <= interval_ff;
    end else if (tick_en && count_ff != 14'h0000) begin
      count_ff <= count_ff - 14'h0001;
    end
  end

  // Frame number only at full speed; kept through a timeout
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_ff <= 11'h000;
    end else if (evt.sof_seen && evt.full_speed) begin
      frame_ff <= evt.frame_num;
    end
  end

  // Timeout event count, saturating, only while enabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      to_cnt_ff <= 3'h0;
    end else if (sof_or_eop) begin
      to_cnt_ff <= 3'h0;
    end else if (to_ien && expire && to_cnt_ff != TO_CNT_MAX) begin
      to_cnt_ff <= to_cnt_ff + 3'h1;
    end
  end

  // Sticky flag; a new timeout beats a same-cycle clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      to_flag_ff <= 1'b0;
    end else if (to_ien && expire) begin
      to_flag_ff <= 1'b1;
    end else if (flag_clr) begin
      to_flag_ff <= 1'b0;
    end
  end

  assign frame_reg = {to_flag_ff, to_cnt_ff, 1'b0, frame_ff};

  sof_reload_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sof_or_eop && !count_wr |=> count_ff == $past(interval_ff))
    else $error("counter not reloaded on frame");
  cnt_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sof_or_eop |=> to_cnt_ff == 3'h0)
    else $error("timeout count not cleared");
  cnt_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !to_ien && !sof_or_eop |=> $stable(to_cnt_ff))
    else $error("timeout count moved while disabled");
  cnt_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    to_ien && expire && to_cnt_ff < TO_CNT_MAX |=> to_cnt_ff == $past(to_cnt_ff) + 3'h1)
    else $error("timeout count did not advance");
  flag_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
    to_ien && expire |=> to_flag_ff)
    else $error("timeout flag not set");
  frame_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !evt.sof_seen |=> $stable(frame_ff))
    else $error("frame changed without SOF");
  tick_dec_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick_en && !sof_or_eop && !count_wr && count_ff > 14'h0000
    |=> count_ff == $past(count_ff) - 14'h0001)
    else $error("counter not decremented on tick");
endmodule
`default_nettype wire

// [design/usbt_top.sv]
// Top: register port, 12 MHz time base, two port timers, OTG control
// Function
// - Three-bit timeout count in frame bits 14:12, saturating at seven.
// - Timeout count clears when SOF or EOP arrives.
// - Timeout count only advances while timeout interrupt enable is set.
// - Full speed SOF frame number captured into frame bits 10:0.
// - Frame number kept unchanged when a timeout happens.
// - Timeout raised, if enabled, when counter expires before next SOF/EOP.
// - Down counter decrements on each 12 MHz tick until it reaches zero, then holds.
// - Count register bits 13:0 show counter; reset value 0x2EE0.
// - Control bit 13 drives the VBUS pull-up enable.
// - Control bit 12 powers down the OTG receiver.
// - Control bit 11 enables the VBUS charge pump.
// - Control bit 10 enables the VBUS discharge pull-down.
// - Control bits 9 and 8 enable D+ and D- pull-ups.
// - Control bits 7 and 6 enable D+ and D- pull-downs.
// - Control bit 2 reads the VBUS pin logic level.
// - Control bit 1 reads the ID pin state.
// - Control bit 0 reads one when VBUS is above valid threshold.
// - Frame bit 15 shows the timeout flag.
// - Writing one to a status flag bit clears it.
`timescale 1ns/1ps
`default_nettype none
module usbt_top
  import usbt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff,
  // Port events from the two serial engines
  input wire usbt_port_evt_type p1_evt,
  input wire usbt_port_evt_type p2_evt,
  // OTG pins on the otg_capable_port
  input wire logic vbus_lvl_pin,
  input wire logic id_pin,
  input wire logic vbus_valid_pin,
  output usbt_otg_pins_type otg_pins_ff
);
  logic [24:0] acc_ff;
  logic tick_ff;
  logic [15:0] otg_ctrl_ff;
  logic [1:0] vbus_sync_ff;
  logic [1:0] id_sync_ff;
  logic [1:0] valid_sync_ff;
  logic p1_ien_ff;
  logic p2_ien_ff;
  logic [13:0] p1_count;
  logic [13:0] p2_count;
  logic [15:0] p1_frame;
  logic [15:0] p2_frame;
  logic p1_flag;
  logic p2_flag;
  logic [15:0] nxt_rdata;
  logic [15:0] otg_read;

  // Shared address match for write decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // 12 MHz tick from 20 MHz clock: fractional accumulator, no second clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= 25'h0000000;
      tick_ff <= 1'b0;
    end else if (acc_ff + TICK_STEP >= TICK_WRAP) begin
      acc_ff <= acc_ff + TICK_STEP - TICK_WRAP;
      tick_ff <= 1'b1;
    end else begin
      acc_ff <= acc_ff + TICK_STEP;
      tick_ff <= 1'b0;
    end
  end

  // Pin inputs pass two flops before any logic reads them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vbus_sync_ff <= 2'h0;
      id_sync_ff <= 2'h0;
      valid_sync_ff <= 2'h0;
    end else begin
      vbus_sync_ff <= {vbus_sync_ff[0], vbus_lvl_pin};
      id_sync_ff <= {id_sync_ff[0], id_pin};
      valid_sync_ff <= {valid_sync_ff[0], vbus_valid_pin};
    end
  end

  // OTG control bits; read-only and reserved bits are masked out
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      otg_ctrl_ff <= OTG_CTRL_RST;
    end else if (reg_wr && hit(reg_addr, ADDR_OTG_CTRL)) begin
      otg_ctrl_ff <= reg_wdata & OTG_WR_MASK;
    end
  end

  // Analog enables driven from flops, one cycle after the write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      otg_pins_ff <= '0;
    end else begin
      otg_pins_ff.vbus_pu_en <= otg_ctrl_ff[OTG_VBUS_PU_BIT];
      otg_pins_ff.rx_pwr_dn <= otg_ctrl_ff[OTG_RX_DIS_BIT];
      otg_pins_ff.pump_en <= otg_ctrl_ff[OTG_PUMP_BIT];
      otg_pins_ff.vbus_dis_en <= otg_ctrl_ff[OTG_DISCH_BIT];
      otg_pins_ff.dp_pu_en <= otg_ctrl_ff[OTG_DP_PU_BIT];
      otg_pins_ff.dm_pu_en <= otg_ctrl_ff[OTG_DM_PU_BIT];
      otg_pins_ff.dp_pd_en <= otg_ctrl_ff[OTG_DP_PD_BIT];
      otg_pins_ff.dm_pd_en <= otg_ctrl_ff[OTG_DM_PD_BIT];
    end
  end

  // Timeout interrupt enables, one per port
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      p1_ien_ff <= 1'b0;
      p2_ien_ff <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, ADDR_P1_IEN)) begin
        p1_ien_ff <= reg_wdata[STAT_TO_BIT];
      end
      if (reg_wr && hit(reg_addr, ADDR_P2_IEN)) begin
        p2_ien_ff <= reg_wdata[STAT_TO_BIT];
      end
    end
  end

  usbt_sof_timer u_p1 (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick_en(tick_ff),
    .evt(p1_evt),
    .count_wr(reg_wr && hit(reg_addr, ADDR_P1_COUNT)),
    .count_wdata(reg_wdata[13:0]),
    .to_ien(p1_ien_ff),
    .flag_clr(reg_wr && hit(reg_addr, ADDR_P1_STAT) && reg_wdata[STAT_TO_BIT]),
    .count_ff(p1_count),
    .frame_reg(p1_frame),
    .to_flag_ff(p1_flag)
  );

  usbt_sof_timer u_p2 (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick_en(tick_ff),
    .evt(p2_evt),
    .count_wr(reg_wr && hit(reg_addr, ADDR_P2_COUNT)),
    .count_wdata(reg_wdata[13:0]),
    .to_ien(p2_ien_ff),
    .flag_clr(reg_wr && hit(reg_addr, ADDR_P2_STAT) && reg_wdata[STAT_TO_BIT]),
    .count_ff(p2_count),
    .frame_reg(p2_frame),
    .to_flag_ff(p2_flag)
  );

  // OTG readback: control bits plus synchronised pin status
  always_comb begin
    otg_read = otg_ctrl_ff;
    otg_read[OTG_VBUS_LVL_BIT] = vbus_sync_ff[1];
    otg_read[OTG_ID_BIT] = id_sync_ff[1];
    otg_read[OTG_VALID_BIT] = valid_sync_ff[1];
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_P1_FRAME: nxt_rdata = p1_frame;
      ADDR_P2_FRAME: nxt_rdata = p2_frame;
      ADDR_P1_COUNT: nxt_rdata = {2'b00, p1_count};
      ADDR_P2_COUNT: nxt_rdata = {2'b00, p2_count};
      ADDR_OTG_CTRL: nxt_rdata = otg_read;
      ADDR_P1_STAT: nxt_rdata = {15'h0000, p1_flag};
      ADDR_P2_STAT: nxt_rdata = {15'h0000, p2_flag};
      ADDR_P1_IEN: nxt_rdata = {15'h0000, p1_ien_ff};
      ADDR_P2_IEN: nxt_rdata = {15'h0000, p2_ien_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // A control write reaches the analog enables two edges later
  sequence otg_write_s;
    reg_wr && hit(reg_addr, ADDR_OTG_CTRL);
  endsequence

  pump_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    otg_write_s |=> ##1 otg_pins_ff.pump_en == $past(reg_wdata[OTG_PUMP_BIT], 2))
    else $error("charge pump enable does not follow write");
  rx_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    otg_write_s |=> ##1 otg_pins_ff.rx_pwr_dn == $past(reg_wdata[OTG_RX_DIS_BIT], 2))
    else $error("receiver power down mismatch");
  vbus_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_OTG_CTRL
    |=> reg_rdata_ff[OTG_VBUS_LVL_BIT] == $past(vbus_sync_ff[1]))
    else $error("VBUS level readback wrong");
  flag_clr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr == ADDR_P1_STAT && reg_wdata[STAT_TO_BIT] && !p1_ien_ff |=> !p1_flag)
    else $error("status flag not cleared by write one");
endmodule
`default_nettype wire

// [tb/usbt_host_model.sv]
// Behavioural model of the bus partner: frame markers and OTG pin levels
`timescale 1ns/1ps
`default_nettype none
module usbt_host_model
  import usbt_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Frame markers toward the two ports
  output usbt_port_evt_type p1_evt,
  output usbt_port_evt_type p2_evt,
  // Analog pin levels
  output logic vbus_lvl_pin,
  output logic id_pin,
  output logic vbus_valid_pin
);
  // Quiet bus and grounded pins at time zero
  initial begin
    p1_evt = '0;
    p2_evt = '0;
    {vbus_lvl_pin, id_pin, vbus_valid_pin} = 3'h0;
  end

  // One-cycle marker; the frame bus shows junk afterwards so nothing relies on it
  task automatic send(input int p, input logic sof, input logic [10:0] frm, input logic fs);
    usbt_port_evt_type e;
    e = {sof, ~sof, frm, fs};
    if (p == 1) p1_evt <= e;
    else p2_evt <= e;
    @(posedge core_clk);
    e = {1'b0, 1'b0, ~frm, fs};
    if (p == 1) p1_evt <= e;
    else p2_evt <= e;
  endtask

  // Pin levels change after an edge, as a slow analog source would
  task automatic set_pins(input logic [2:0] v);
    {vbus_lvl_pin, id_pin, vbus_valid_pin} <= v;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the SOF timeout and OTG control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench
  import usbt_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_ff;
  usbt_port_evt_type p1_evt;
  usbt_port_evt_type p2_evt;
  logic vbus_lvl_pin;
  logic id_pin;
  logic vbus_valid_pin;
  usbt_otg_pins_type otg_pins_ff;
  int num_checks = 0;
  int miscompares = 0;

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  usbt_top dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .p1_evt(p1_evt),
    .p2_evt(p2_evt), .vbus_lvl_pin(vbus_lvl_pin), .id_pin(id_pin),
    .vbus_valid_pin(vbus_valid_pin), .otg_pins_ff(otg_pins_ff));

  usbt_host_model host (.core_clk(core_clk), .p1_evt(p1_evt), .p2_evt(p2_evt),
    .vbus_lvl_pin(vbus_lvl_pin), .id_pin(id_pin), .vbus_valid_pin(vbus_valid_pin));

  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Register cycles; an idle cycle after each keeps strobes from being reassigned in one step
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata_ff;
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    logic [15:0] d;
    rd(ADDR_P1_COUNT, d); `CHK(d, 16'h2EE0)
    rd(ADDR_P2_COUNT, d); `CHK(d, 16'h2EE0)
    rd(ADDR_P1_FRAME, d); `CHK(d, 16'h0000)
    rd(16'hC0F0, d); `CHK(d, 16'h0000)
    $display("test reset values done");
  endtask

  task automatic t_otg;
    logic [15:0] v;
    logic [15:0] d;
    for (int b = 6; b < 14; b++) begin
      v = 16'h0001 << b;
      wr(ADDR_OTG_CTRL, v);
      @(negedge core_clk);
      `CHK(8'(otg_pins_ff), v[13:6])
      @(posedge core_clk);
      rd(ADDR_OTG_CTRL, d); `CHK(d[15:3], v[15:3])
    end
    // Pump on, then allow VBUS to settle before trusting the valid flag
    wr(ADDR_OTG_CTRL, 16'h0800);
    repeat (200) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      host.set_pins(3'(i));
      repeat (4) @(posedge core_clk);
      rd(ADDR_OTG_CTRL, d); `CHK(d[2:0], 3'(i))
    end
    wr(ADDR_OTG_CTRL, 16'h0000);
    $display("test otg control done");
  endtask

  // Down counter rate: 30 loaded, about 16 ticks of 12 MHz pass before the read
  task automatic t_rate;
    logic [15:0] d;
    wr(ADDR_P1_COUNT, 16'h001E);
    repeat (25) @(posedge core_clk);
    rd(ADDR_P1_COUNT, d); `CHK(d >= 16'd12 && d <= 16'd16, 1'b1)
    $display("test count rate done");
  endtask

  task automatic t_timeout(input logic [15:0] af, ac, as, ai, input int p);
    logic [15:0] d;
    int n;
    host.send(p, 1'b1, 11'h5A3, 1'b1);
    rd(af, d); `CHK(d[10:0], 11'h5A3)
    host.send(p, 1'b1, 11'h111, 1'b0);
    rd(af, d); `CHK(d[10:0], 11'h5A3)
    wr(ai, 16'h0001);
    rd(ai, d); `CHK(d, 16'h0001)
    wr(ac, 16'h0006);
    n = 0;
    d = 16'h0000;
    while (d[0] !== 1'b1 && n < 40) begin
      rd(as, d);
      n++;
    end
    `CHK(d[0], 1'b1)
    // A flag that never came is already counted; stop rather than run on
    if (d[0] !== 1'b1) final_report();
    rd(af, d); `CHK(d, 16'h95A3)
    rd(ac, d); `CHK(d, 16'h0000)
    // Eight more expiries must not wrap the three-bit count
    repeat (8) begin
      wr(ac, 16'h0006);
      repeat (20) @(posedge core_clk);
    end
    rd(af, d); `CHK(d[14:12], 3'h7)
    wr(as, 16'h0001);
    rd(as, d); `CHK(d[0], 1'b0)
    rd(af, d); `CHK(d[15], 1'b0)
    host.send(p, 1'b0, 11'h000, 1'b1);
    rd(ac, d); `CHK(d >= 16'd2 && d <= 16'd6, 1'b1)
    rd(af, d); `CHK(d[14:12], 3'h0)
    repeat (20) @(posedge core_clk);
    rd(af, d); `CHK(d[15:12], 4'h9)
    wr(ai, 16'h0000);
    wr(as, 16'h0001);
    wr(ac, 16'h0006);
    repeat (20) @(posedge core_clk);
    rd(af, d); `CHK(d[15:12], 4'h1)
    rd(as, d); `CHK(d[0], 1'b0)
    $display("test timeout on port %0d done", p);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_otg();
    t_rate();
    t_timeout(ADDR_P1_FRAME, ADDR_P1_COUNT, ADDR_P1_STAT, ADDR_P1_IEN, 1);
    t_timeout(ADDR_P2_FRAME, ADDR_P2_COUNT, ADDR_P2_STAT, ADDR_P2_IEN, 2);
    final_report();
  end
endmodule
`default_nettype wire
